// File: verilog/usart_regs.svh
// register map, field positions, reset values and timing counts
`ifndef USART_REGS_SVH
`define USART_REGS_SVH

`define USART_ADR_DATA 6'h00
`define USART_ADR_STATUS 6'h01
`define USART_ADR_CTRL 6'h02
`define USART_ADR_FORMAT 6'h03
`define USART_ADR_BAUD 6'h04

`define USART_ST_RXC 7
`define USART_ST_TXC 6
`define USART_ST_UDRE 5
`define USART_ST_U2X 1
`define USART_ST_GIE 0

`define USART_CT_TXCIE 6
`define USART_CT_UDRIE 5
`define USART_CT_RXEN 4
`define USART_CT_TX_ENABLE_BIT 3
`define USART_CT_RXB8 1
`define USART_CT_TX_NINTH_BIT 0

`define USART_FM_CPOL 7
`define USART_FM_SYNC 6
`define USART_FM_PEN 5
`define USART_FM_PODD 4
`define USART_FM_SBS 3

`define USART_RST_CSIZE 3'h3
`define USART_CSIZE_NINE 3'h7
`define USART_OS_NORMAL 4'hF
`define USART_OS_DOUBLE 4'h7

`endif

// File: verilog/usart_pkg.sv
// types of the serial port datapath
package usart_pkg;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2
  } usart_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE, RX_START, RX_DATA, RX_STOP
  } usart_rx_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic tx_en;
    logic rx_en;
    logic udrie;
    logic txcie;
    logic gie;
    logic b8;
    logic [2:0] csize;
    logic sbs;
    logic pen;
    logic podd;
    logic sync;
    logic cpol;
    logic u2x;
    logic [11:0] baud;
    logic [11:0] pre_cnt;
    logic [7:0] buf_data;
    logic buf_b8;
    logic buf_full;
    usart_tx_state_t txs;
    logic [8:0] tx_sh;
    logic tx_par;
    logic [3:0] tx_idx;
    logic [3:0] tx_os;
    logic txd;
    logic tx_own;
    logic txc;
    usart_rx_state_t rxs;
    logic [8:0] rx_sh;
    logic [3:0] rx_idx;
    logic [3:0] rx_os;
    logic [8:0] rx_data;
    logic rx_full;
    logic rxd_s1;
    logic rxd_s2;
    logic rxd_s3;
    logic rxd_f;
    logic xck_s1;
    logic xck_s2;
    logic xck_s3;
    logic xck_f;
    logic irq_udre;
    logic irq_txc;
  } usart_state_t;

endpackage

// File: verilog/usart_core.sv
// serial port transmitter and receiver with a wishbone register slave
`timescale 1ns/10ps
`include "usart_regs.svh"

module usart_core (
  input wire logic core_clk, // system clock, 250 MHz
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic serial_in_pin, // receive line
  input wire logic ext_xfer_clock_pin, // external transfer clock
  output logic serial_out_pin, // transmit line level
  output logic serial_out_oe, // transmitter owns the output pin
  output logic serial_in_owned, // receiver owns the input pin
  output logic ext_clock_owned, // external clock pin overridden
  input wire logic tx_complete_irq_taken, // pulse: tx-complete irq executed
  output logic tx_empty_irq, // buffer-empty interrupt request
  output logic tx_complete_irq, // tx-complete interrupt request
  output logic rx_complete_flag // receive buffer holds unread data
);

  usart_pkg::usart_state_t st_r;
  usart_pkg::usart_state_t st_nxt;

  logic req;
  logic [5:0] widx;
  logic [3:0] os_max;
  logic os_tick;
  logic xck_rise;
  logic xck_fall;
  logic chg_edge;
  logic smp_edge;
  logic tx_tick;
  logic rx_smp;
  logic [3:0] nbits;
  logic [8:0] mask;
  logic [8:0] tx_word;
  logic frame_end;
  logic [7:0] rd_byte;

  always_comb
  begin
    st_nxt = st_r;
    frame_end = 1'b0;
    tx_word = 9'h000;
    rd_byte = 8'h00;
    st_nxt.ack = 1'b0;
    req = wb_cyc_i & wb_stb_i & ~st_r.ack;
    widx = wb_adr_i[7:2];

    // three-stage pin synchronisers; a level counts once stages 2 and 3 agree
    st_nxt.rxd_s1 = serial_in_pin;
    st_nxt.rxd_s2 = st_r.rxd_s1;
    st_nxt.rxd_s3 = st_r.rxd_s2;
    if (st_r.rxd_s2 == st_r.rxd_s3)
    begin
      st_nxt.rxd_f = st_r.rxd_s3;
    end
    st_nxt.xck_s1 = ext_xfer_clock_pin;
    st_nxt.xck_s2 = st_r.xck_s1;
    st_nxt.xck_s3 = st_r.xck_s2;
    xck_rise = (st_r.xck_s2 == st_r.xck_s3) & st_r.xck_s3 & ~st_r.xck_f;
    xck_fall = (st_r.xck_s2 == st_r.xck_s3) & ~st_r.xck_s3 & st_r.xck_f;
    if (st_r.xck_s2 == st_r.xck_s3)
    begin
      st_nxt.xck_f = st_r.xck_s3;
    end
    chg_edge = st_r.cpol ? xck_fall : xck_rise;
    smp_edge = st_r.cpol ? xck_rise : xck_fall;

    // prescaler ticks every divisor+1 cycles; 16 or 8 ticks make one bit
    os_max = st_r.u2x ? `USART_OS_DOUBLE : `USART_OS_NORMAL;
    os_tick = (st_r.pre_cnt == st_r.baud);
    st_nxt.pre_cnt = os_tick ? 12'h000 : st_r.pre_cnt + 12'h001;
    if (os_tick)
    begin
      st_nxt.tx_os = (st_r.tx_os == os_max) ? 4'h0 : st_r.tx_os + 4'h1;
    end
    tx_tick = st_r.sync ? chg_edge : (os_tick & (st_r.tx_os == os_max));

    nbits = (st_r.csize == `USART_CSIZE_NINE) ? 4'h9 :
      {2'b00, st_r.csize[1:0]} + 4'h5;
    mask = 9'h1FF >> (4'h9 - nbits);

    // transmitter
    case (st_r.txs)
      usart_pkg::TX_IDLE:
      begin
        st_nxt.txd = 1'b1;
      end
      usart_pkg::TX_START:
      begin
        if (tx_tick)
        begin
          st_nxt.txd = st_r.tx_sh[0];
          st_nxt.tx_sh = st_r.tx_sh >> 1;
          st_nxt.tx_idx = nbits - 4'h1;
          st_nxt.txs = usart_pkg::TX_DATA;
        end
      end
      usart_pkg::TX_DATA:
      begin
        if (tx_tick)
        begin
          if (st_r.tx_idx != 4'h0)
          begin
            st_nxt.txd = st_r.tx_sh[0];
            st_nxt.tx_sh = st_r.tx_sh >> 1;
            st_nxt.tx_idx = st_r.tx_idx - 4'h1;
          end
          else if (st_r.pen)
          begin
            st_nxt.txd = st_r.tx_par;
            st_nxt.txs = usart_pkg::TX_PAR;
          end
          else
          begin
            st_nxt.txd = 1'b1;
            st_nxt.txs = usart_pkg::TX_STOP1;
          end
        end
      end
      usart_pkg::TX_PAR:
      begin
        if (tx_tick)
        begin
          st_nxt.txd = 1'b1;
          st_nxt.txs = usart_pkg::TX_STOP1;
        end
      end
      usart_pkg::TX_STOP1:
      begin
        if (tx_tick)
        begin
          if (st_r.sbs)
          begin
            st_nxt.txs = usart_pkg::TX_STOP2;
          end
          else
          begin
            frame_end = 1'b1;
          end
        end
      end
      usart_pkg::TX_STOP2:
      begin
        frame_end = tx_tick;
      end
      default:
      begin
        st_nxt.txs = usart_pkg::TX_IDLE;
      end
    endcase

    if (frame_end)
    begin
      st_nxt.txs = usart_pkg::TX_IDLE;
      st_nxt.txd = 1'b1;
    end

    // tx-complete clears first so that a frame ending now still sets it
    if (tx_complete_irq_taken)
    begin
      st_nxt.txc = 1'b0;
    end
    if (req & wb_we_i & wb_sel_i[0] & (widx == `USART_ADR_STATUS) &
      wb_dat_i[`USART_ST_TXC])
    begin
      st_nxt.txc = 1'b0;
    end
    if (frame_end & ~st_r.buf_full)
    begin
      st_nxt.txc = 1'b1;
    end

    // buffer moves on when the shifter is idle or right after the last stop;
    // a pending word is still sent after tx enable is cleared
    if (st_r.buf_full & st_r.tx_own &
      ((st_r.txs == usart_pkg::TX_IDLE) | frame_end))
    begin
      tx_word = {st_r.buf_b8, st_r.buf_data} & mask;
      st_nxt.tx_sh = tx_word;
      st_nxt.tx_par = (^tx_word) ^ st_r.podd;
      st_nxt.buf_full = 1'b0;
      st_nxt.txs = usart_pkg::TX_START;
      st_nxt.txd = 1'b0;
      st_nxt.tx_os = 4'h0;
    end

    // receiver
    rx_smp = st_r.sync ? smp_edge : (os_tick & (st_r.rx_os == os_max));
    if (os_tick)
    begin
      st_nxt.rx_os = (st_r.rx_os == os_max) ? 4'h0 : st_r.rx_os + 4'h1;
    end
    case (st_r.rxs)
      usart_pkg::RX_IDLE:
      begin
        st_nxt.rx_idx = nbits;
        if (st_r.sync)
        begin
          if (smp_edge & ~st_r.rxd_f)
          begin
            st_nxt.rxs = usart_pkg::RX_DATA;
          end
        end
        else if (~st_r.rxd_f)
        begin
          st_nxt.rx_os = 4'h0;
          st_nxt.rxs = usart_pkg::RX_START;
        end
      end
      usart_pkg::RX_START:
      begin
        // a start bit is valid only if still low at its middle
        if (os_tick & (st_r.rx_os == (os_max >> 1)))
        begin
          st_nxt.rx_os = 4'h0;
          st_nxt.rxs = st_r.rxd_f ? usart_pkg::RX_IDLE :
            usart_pkg::RX_DATA;
        end
      end
      usart_pkg::RX_DATA:
      begin
        if (rx_smp)
        begin
          st_nxt.rx_sh = {st_r.rxd_f, st_r.rx_sh[8:1]};
          st_nxt.rx_idx = st_r.rx_idx - 4'h1;
          if (st_r.rx_idx == 4'h1)
          begin
            st_nxt.rx_idx = {3'b000, st_r.pen};
            st_nxt.rxs = usart_pkg::RX_STOP;
          end
        end
      end
      usart_pkg::RX_STOP:
      begin
        // parity bit is skipped; only the first stop bit ends the frame
        if (rx_smp)
        begin
          st_nxt.rx_idx = 4'h0;
          if (st_r.rx_idx == 4'h0)
          begin
            st_nxt.rxs = usart_pkg::RX_IDLE;
          end
        end
      end
      default:
      begin
        st_nxt.rxs = usart_pkg::RX_IDLE;
      end
    endcase

    // register slave: answer one cycle after the request, unmapped reads 0
    if (req)
    begin
      st_nxt.ack = 1'b1;
      st_nxt.rdat = 32'h0000_0000;
      case (widx)
        `USART_ADR_DATA:
        begin
          st_nxt.rdat[7:0] = st_r.rx_data[7:0];
          if (~wb_we_i)
          begin
            st_nxt.rx_full = 1'b0;
          end
          else if (wb_sel_i[0])
          begin
            st_nxt.buf_data = wb_dat_i[7:0];
            st_nxt.buf_b8 = st_r.b8;
            st_nxt.buf_full = 1'b1;
          end
        end
        `USART_ADR_STATUS:
        begin
          rd_byte[`USART_ST_RXC] = st_r.rx_full;
          rd_byte[`USART_ST_TXC] = st_r.txc;
          rd_byte[`USART_ST_UDRE] = ~st_r.buf_full;
          rd_byte[`USART_ST_U2X] = st_r.u2x;
          rd_byte[`USART_ST_GIE] = st_r.gie;
          st_nxt.rdat[7:0] = rd_byte;
          if (wb_we_i & wb_sel_i[0])
          begin
            st_nxt.u2x = wb_dat_i[`USART_ST_U2X];
            st_nxt.gie = wb_dat_i[`USART_ST_GIE];
          end
        end
        `USART_ADR_CTRL:
        begin
          rd_byte[`USART_CT_TXCIE] = st_r.txcie;
          rd_byte[`USART_CT_UDRIE] = st_r.udrie;
          rd_byte[`USART_CT_RXEN] = st_r.rx_en;
          rd_byte[`USART_CT_TX_ENABLE_BIT] = st_r.tx_en;
          rd_byte[`USART_CT_RXB8] = st_r.rx_data[8];
          rd_byte[`USART_CT_TX_NINTH_BIT] = st_r.b8;
          st_nxt.rdat[7:0] = rd_byte;
          if (wb_we_i & wb_sel_i[0])
          begin
            st_nxt.txcie = wb_dat_i[`USART_CT_TXCIE];
            st_nxt.udrie = wb_dat_i[`USART_CT_UDRIE];
            st_nxt.rx_en = wb_dat_i[`USART_CT_RXEN];
            st_nxt.tx_en = wb_dat_i[`USART_CT_TX_ENABLE_BIT];
            st_nxt.b8 = wb_dat_i[`USART_CT_TX_NINTH_BIT];
          end
        end
        `USART_ADR_FORMAT:
        begin
          rd_byte = {st_r.cpol, st_r.sync, st_r.pen, st_r.podd, st_r.sbs,
            st_r.csize};
          st_nxt.rdat[7:0] = rd_byte;
          if (wb_we_i & wb_sel_i[0])
          begin
            st_nxt.cpol = wb_dat_i[`USART_FM_CPOL];
            st_nxt.sync = wb_dat_i[`USART_FM_SYNC];
            st_nxt.pen = wb_dat_i[`USART_FM_PEN];
            st_nxt.podd = wb_dat_i[`USART_FM_PODD];
            st_nxt.sbs = wb_dat_i[`USART_FM_SBS];
            st_nxt.csize = wb_dat_i[2:0];
          end
        end
        `USART_ADR_BAUD:
        begin
          st_nxt.rdat[11:0] = st_r.baud;
          if (wb_we_i & wb_sel_i[0])
          begin
            st_nxt.baud[7:0] = wb_dat_i[7:0];
          end
          if (wb_we_i & wb_sel_i[1])
          begin
            st_nxt.baud[11:8] = wb_dat_i[11:8];
          end
        end
        default:
        begin
          st_nxt.rdat = 32'h0000_0000;
        end
      endcase
    end

    // a frame landing in the same cycle as a data read is kept
    if ((st_r.rxs == usart_pkg::RX_STOP) & rx_smp & (st_r.rx_idx == 4'h0))
    begin
      st_nxt.rx_data = (st_r.rx_sh >> (4'h9 - nbits));
      st_nxt.rx_full = 1'b1;
    end

    // receiver stops at once and drops buffered data when disabled
    if (~st_r.rx_en)
    begin
      st_nxt.rxs = usart_pkg::RX_IDLE;
      st_nxt.rx_full = 1'b0;
    end

    // pin stays with the transmitter until nothing is left to send
    st_nxt.tx_own = st_r.tx_en | st_nxt.buf_full |
      (st_nxt.txs != usart_pkg::TX_IDLE);
    st_nxt.irq_udre = st_r.gie & st_r.udrie & ~st_r.buf_full;
    st_nxt.irq_txc = st_r.gie & st_r.txcie & st_r.txc;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= '{txs: usart_pkg::TX_IDLE, rxs: usart_pkg::RX_IDLE,
        csize: `USART_RST_CSIZE, txd: 1'b1, rxd_s1: 1'b1, rxd_s2: 1'b1,
        rxd_s3: 1'b1, rxd_f: 1'b1, default: '0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = st_r.rdat;
  assign wb_ack_o = st_r.ack;
  assign serial_out_pin = st_r.txd;
  assign serial_out_oe = st_r.tx_own;
  assign serial_in_owned = st_r.rx_en;
  assign ext_clock_owned = st_r.sync & (st_r.tx_own | st_r.rx_en);
  assign tx_empty_irq = st_r.irq_udre;
  assign tx_complete_irq = st_r.irq_txc;
  assign rx_complete_flag = st_r.rx_full;

endmodule // usart_core

// File: dv/usart_core_checker.sv
// concurrent checks on the serial port core pins
`timescale 1ns/10ps
`include "usart_regs.svh"
module usart_core_checker (
  input wire logic core_clk, // clock
  input wire logic arst_n, // reset, active low
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic wb_ack_o, // acknowledge
  input wire logic serial_out_pin, // tx line
  input wire logic serial_out_oe, // tx owns pin
  input wire logic serial_in_owned, // rx owns pin
  input wire logic tx_complete_irq, // tx-complete request
  input wire logic rx_complete_flag // rx data waiting
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_req: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_needs_req: assert property (
    wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without a request");
  a_line_idle_high: assert property (!serial_out_oe |-> serial_out_pin)
    else $error("released tx line not high");
  a_txc_line_high: assert property (
    $rose(tx_complete_irq) |-> serial_out_pin[*2])
    else $error("tx complete raised during a frame");
  a_release_when_idle: assert property (
    $fell(serial_out_oe) |-> $past(serial_out_pin, 1))
    else $error("tx pin released mid frame");
  a_rx_owned_follows: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
    && wb_adr_i[7:2] == `USART_ADR_CTRL
    |-> ##2 serial_in_owned == $past(wb_dat_i[`USART_CT_RXEN], 2))
    else $error("rx pin ownership not following enable");
  a_rxc_needs_en: assert property (
    $rose(rx_complete_flag) |-> serial_in_owned)
    else $error("rx data flagged with receiver off");
endmodule // usart_core_checker

bind usart_core usart_core_checker u_chk (.core_clk, .arst_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
  .serial_out_pin, .serial_out_oe, .serial_in_owned, .tx_complete_irq,
  .rx_complete_flag);

// File: dv/usart_serial_node.sv
// remote serial node: sends and captures frames on the data lines
`timescale 1ns/10ps
module usart_serial_node #(
  parameter int BIT = 16
) (
  input wire logic core_clk, // system clock
  input wire logic line_in, // tx line seen by the node
  output logic line_out, // node drives the rx line
  output logic xck // external clock, held low; the node never toggles it
);
  initial
  begin
    line_out = 1'b1;
    xck = 1'b0;
  end
  // start bit then n bits lsb first; caller includes the stop bits
  task automatic send(input logic [11:0] bits, input int n);
    line_out <= 1'b0;
    repeat (BIT) @(posedge core_clk);
    for (int i = 0; i < n; i++)
    begin
      line_out <= bits[i];
      repeat (BIT) @(posedge core_clk);
    end
  endtask
  // samples mid bit; bits not sampled read back high
  task automatic recv(input int n, output logic [11:0] bits, output bit ok);
    int t;
    bits = 12'hFFF;
    t = 0;
    while (line_in !== 1'b0 && t < 2000)
    begin
      @(posedge core_clk);
      t++;
    end
    repeat (BIT / 2) @(posedge core_clk);
    ok = (t < 2000) && (line_in === 1'b0);
    for (int i = 0; i < n; i++)
    begin
      repeat (BIT) @(posedge core_clk);
      bits[i] = line_in;
    end
  endtask
endmodule // usart_serial_node

// File: dv/usart_tx_rx_datapath_test.sv
// self-checking bench for the serial port core
`timescale 1ns/10ps
`include "usart_regs.svh"
module usart_tx_rx_datapath_test;
  logic core_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic rx_line, xck, serial_out_pin, serial_out_oe, serial_in_owned;
  logic ext_clock_owned, tx_complete_irq_taken, tx_empty_irq;
  logic tx_complete_irq, rx_complete_flag;
  wire tx_line = serial_out_oe ? serial_out_pin : 1'b1; // pull-up
  int err_count, samples_checked;

  usart_core u_usart_core (.core_clk, .arst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .serial_in_pin(rx_line), .ext_xfer_clock_pin(xck), .serial_out_pin,
    .serial_out_oe, .serial_in_owned, .ext_clock_owned,
    .tx_complete_irq_taken, .tx_empty_irq, .tx_complete_irq,
    .rx_complete_flag);
  usart_serial_node u_usart_serial_node (.core_clk, .line_in(tx_line),
    .line_out(rx_line), .xck);

  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e,
    input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic bound(input int n);
    if (n >= 2000)
    begin
      chk("wait bound", 0, 1);
      wrap_up();
    end
  endtask
  task automatic bus(input logic we, input logic [5:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {a, 2'b00};
    wb_dat_i <= d;
    // ack and read data are taken at the rising edge that samples ack high
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 2000);
    bound(n);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk("read", e, q);
  endtask
  task automatic wait_hi(input bit rx);
    int n;
    n = 0;
    while ((rx ? rx_complete_flag : tx_complete_irq) !== 1'b1 && n < 2000)
    begin
      @(posedge core_clk);
      n++;
    end
    bound(n);
  endtask
  // stop bits stay high beyond the data and parity
  function automatic logic [11:0] frm(input logic [8:0] d, input int n,
    input logic pe, input logic po);
    logic [11:0] f;
    f = 12'hFFF;
    for (int i = 0; i < n; i++)
    begin
      f[i] = d[i];
      po ^= d[i];
    end
    if (pe)
      f[n] = po;
    return f;
  endfunction
  task automatic txf(input logic [8:0] d, input int n, input logic pe,
    input logic po);
    logic [11:0] g;
    bit ok;
    u_usart_serial_node.recv(n + pe + 1, g, ok);
    chk("start bit", 1, ok);
    chk("frame", 32'(frm(d, n, pe, po)), 32'(g));
  endtask

  task automatic sc_setup;
    rd(`USART_ADR_STATUS, 32'h20);
    rd(`USART_ADR_FORMAT, 32'h03);
    wr(6'h0F, 32'hFF);
    rd(6'h0F, 32'h0);
    rd(`USART_ADR_CTRL, 32'h0);
    wr(`USART_ADR_STATUS, 32'h01);
    wr(`USART_ADR_CTRL, 32'h78);
    @(negedge core_clk);
    @(negedge core_clk);
    chk("out oe", 1, serial_out_oe);
    chk("in owned", 1, serial_in_owned);
    chk("empty irq", 1, tx_empty_irq);
  endtask
  task automatic sc_back_to_back;
    fork
      begin
        txf(9'h0A5, 8, 0, 0);
        txf(9'h03C, 8, 0, 0);
      end
      begin
        wr(`USART_ADR_DATA, 32'hA5);
        wr(`USART_ADR_DATA, 32'h3C);
        rd(`USART_ADR_STATUS, 32'h01);
      end
    join
    wait_hi(0);
    rd(`USART_ADR_STATUS, 32'h61);
    @(posedge core_clk);
    tx_complete_irq_taken <= 1'b1;
    @(posedge core_clk);
    tx_complete_irq_taken <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk("txc irq", 0, tx_complete_irq);
  endtask
  task automatic sc_formats;
    logic [7:0] fm[5] = '{8'h28, 8'h31, 8'h02, 8'h23, 8'h3F};
    int nb[5] = '{5, 6, 7, 8, 9};
    wr(`USART_ADR_BAUD, 32'h1);
    wr(`USART_ADR_STATUS, 32'h03);
    for (int i = 0; i < 5; i++)
    begin
      wr(`USART_ADR_FORMAT, 32'(fm[i]));
      if (nb[i] == 9)
        wr(`USART_ADR_CTRL, 32'h79);
      fork
        txf(9'h1DA, nb[i], fm[i][5], fm[i][4]);
        wr(`USART_ADR_DATA, 32'hDA);
      join
      repeat (40) @(posedge core_clk);
    end
    wr(`USART_ADR_CTRL, 32'h78);
    wr(`USART_ADR_STATUS, 32'h43);
    rd(`USART_ADR_STATUS, 32'h23);
  endtask
  task automatic sc_receive;
    wr(`USART_ADR_FORMAT, 32'h03);
    u_usart_serial_node.send(frm(9'h0FF, 8, 0, 0), 9);
    wait_hi(1);
    rd(`USART_ADR_DATA, 32'hFF);
    rd(`USART_ADR_STATUS, 32'h23);
    wr(`USART_ADR_FORMAT, 32'h08);
    u_usart_serial_node.send(frm(9'h015, 5, 0, 0), 7);
    wait_hi(1);
    rd(`USART_ADR_DATA, 32'h15);
    wr(`USART_ADR_FORMAT, 32'h03);
  endtask
  task automatic sc_disable;
    fork
      txf(9'h05A, 8, 0, 0);
      begin
        wr(`USART_ADR_DATA, 32'h5A);
        wr(`USART_ADR_CTRL, 32'h50);
        chk("oe held", 1, serial_out_oe);
      end
    join
    repeat (24) @(negedge core_clk);
    chk("oe freed", 0, serial_out_oe);
    chk("empty masked", 0, tx_empty_irq);
    wr(`USART_ADR_FORMAT, 32'h43);
    @(negedge core_clk);
    chk("xck owned", 1, ext_clock_owned);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial
  begin
    #300000;
    chk("run time", 0, 1);
    wrap_up();
  end
  initial
  begin
    arst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    tx_complete_irq_taken = 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    sc_setup();
    sc_back_to_back();
    sc_formats();
    sc_receive();
    sc_disable();
    wrap_up();
  end
endmodule // usart_tx_rx_datapath_test
